//--- verilog/wsf_map.svh
/*
 Offsets, field positions, reset values, character codes and timing figures
 for the continuous weight/status frame transmitter.
 Assumes a 20 MHz clock and a word-wide register port with 4-bit byte address.
*/
`ifndef WSF_MAP_SVH
`define WSF_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define WSF_REG_CTRL 4'h0
`define WSF_REG_EVENT 4'h4
`define WSF_REG_MASK 4'h8
`define WSF_REG_STATE 4'hC

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define WSF_CTRL_TX_EN 0
`define WSF_CTRL_CRLF_EN 1
`define WSF_CTRL_RESET 32'h0000_0003
`define WSF_EV_FRAME_DONE 0
`define WSF_EV_KEY_CMD 1
`define WSF_EV_BAD_CMD 2
`define WSF_EV_WIDTH 3
`define WSF_MASK_RESET 3'h0

// ----------------------------------------------------------------
// Character codes
// ----------------------------------------------------------------
`define WSF_CH_START 8'h02
`define WSF_CH_CR 8'h0D
`define WSF_CH_LF 8'h0A
`define WSF_CH_ZERO 8'h30
`define WSF_CH_SPACE 8'h20
`define WSF_CH_P 8'h50
`define WSF_CH_Z 8'h5A
`define WSF_CH_T 8'h54
`define WSF_CH_C 8'h43
`define WSF_THIRD_FLAG 8'h30
`define WSF_MSG_UNDER 48'h554E_4445_5220
`define WSF_MSG_OVER 48'h4F56_4552_2020
`define WSF_MSG_AOUT 48'h412E_4F55_5420
`define WSF_MSG_LVOLT 48'h4C2D_564F_4C54
`define WSF_MSG_HVOLT 48'h482D_564F_4C54

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WSF_CLK_HZ 20000000
`define WSF_HOLDOFF_S 20
`define WSF_HOLDOFF_CYCLES (`WSF_HOLDOFF_S * `WSF_CLK_HZ)

`endif

//--- verilog/wsf_pkg.sv
/*
 Types for the continuous weight/status frame transmitter.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package wsf_pkg;

    // ----------------------------------------------------------------
    // Frame sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        WSF_HOLD = 4'b0001,
        WSF_LOAD = 4'b0010,
        WSF_SEND = 4'b0100,
        WSF_CSUM = 4'b1000
    } wsf_state_t;

    // ----------------------------------------------------------------
    // Weight field override
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        WSF_W_OK = 3'h0,
        WSF_W_UNDER = 3'h1,
        WSF_W_OVER = 3'h2,
        WSF_W_ADC_OUT = 3'h3,
        WSF_W_LOW_SUPPLY = 3'h4,
        WSF_W_HIGH_SUPPLY = 3'h5
    } wsf_wcond_t;

endpackage

//--- verilog/wsf_tx.sv
/*
 Continuous weight/status frame transmitter with serial key commands.
 Assumes weight, tare, flags, byte sink and byte source all run on clk;
 the byte sink is a UART transmitter with a valid/ready handshake.
*/
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "wsf_map.svh"

module wsf_tx #(
    parameter int unsigned HOLDOFF_CYCLES = `WSF_HOLDOFF_CYCLES,
    parameter int unsigned DIGITS = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    input wire logic [23:0] weight_bcd,
    input wire logic [23:0] tare_bcd,
    input wire logic [2:0] dec_code,
    input wire logic [1:0] incr_code,
    input wire logic is_net,
    input wire logic is_negative,
    input wire logic is_error,
    input wire logic is_unstable,
    input wire logic power_on_zeroed,
    input wire logic [2:0] weight_cond,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic key_print,
    output logic key_zero,
    output logic key_tare,
    output logic key_clear
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (DIGITS != 6) begin : g_bad_digits
        $error("wsf_tx serves six-digit fields only");
    end
    if (HOLDOFF_CYCLES < 1) begin : g_bad_hold
        $error("wsf_tx holdoff must be at least one cycle");
    end

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    wsf_pkg::wsf_state_t state;
    logic [31:0] hold_cnt;
    logic hold_done;
    logic tx_en;
    logic crlf_en;
    logic [`WSF_EV_WIDTH-1:0] ev_stat;
    logic [`WSF_EV_WIDTH-1:0] ev_mask;
    logic [`WSF_EV_WIDTH-1:0] ev_set;
    logic [143:0] frame_sr;
    logic [4:0] byte_left;
    logic [7:0] sum;
    logic [47:0] w_digits;
    logic [47:0] t_digits;
    logic [47:0] w_field;
    logic [DIGITS:0] w_lead;
    logic [DIGITS:0] t_lead;
    logic [7:0] flag_a;
    logic [7:0] flag_b;
    logic take;
    logic [7:0] next_byte;
    logic load_go;
    logic send_go;
    logic sum_go;
    localparam logic [31:0] CTRL_RESET = `WSF_CTRL_RESET;

    // ----------------------------------------------------------------
    // Digit fields
    // ----------------------------------------------------------------
    assign w_lead[DIGITS] = 1'b1;
    assign t_lead[DIGITS] = 1'b1;
    for (genvar i = 0; i < DIGITS; i++) begin : g_digit
        logic w_zero;
        logic t_zero;
        assign w_zero = (weight_bcd[4*i +: 4] == 4'h0);
        assign t_zero = (tare_bcd[4*i +: 4] == 4'h0);
        assign w_lead[i] = w_lead[i+1] & w_zero;
        assign t_lead[i] = t_lead[i+1] & t_zero;
        // Leading zeros blank, least digit always shown
        assign w_digits[8*i +: 8] = (i != 0 && w_lead[i]) ? `WSF_CH_SPACE :
                                    (`WSF_CH_ZERO | {4'h0, weight_bcd[4*i +: 4]});
        assign t_digits[8*i +: 8] = (i != 0 && t_lead[i]) ? `WSF_CH_SPACE :
                                    (`WSF_CH_ZERO | {4'h0, tare_bcd[4*i +: 4]});
    end

    always_comb begin
        unique case (weight_cond)
            wsf_pkg::WSF_W_UNDER: w_field = `WSF_MSG_UNDER;
            wsf_pkg::WSF_W_OVER: w_field = `WSF_MSG_OVER;
            wsf_pkg::WSF_W_ADC_OUT: w_field = `WSF_MSG_AOUT;
            wsf_pkg::WSF_W_LOW_SUPPLY: w_field = `WSF_MSG_LVOLT;
            wsf_pkg::WSF_W_HIGH_SUPPLY: w_field = `WSF_MSG_HVOLT;
            default: w_field = w_digits;
        endcase
    end

    // ----------------------------------------------------------------
    // Flag bytes
    // ----------------------------------------------------------------
    assign flag_a = {1'b0, 2'b11, incr_code[1], incr_code[0], dec_code[2], dec_code[1], dec_code[0]};
    assign flag_b = {1'b0, power_on_zeroed, 2'b11, is_unstable, is_error, is_negative, is_net};

    // ----------------------------------------------------------------
    // Power-on holdoff
    // ----------------------------------------------------------------
    assign hold_done = (hold_cnt >= HOLDOFF_CYCLES);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_cnt <= 32'h0000_0000;
        end else if (!hold_done) begin
            hold_cnt <= hold_cnt + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // Frame sequencer
    // ----------------------------------------------------------------
    assign take = !tx_valid || tx_ready;
    assign next_byte = frame_sr[143:136];
    assign load_go = (state == wsf_pkg::WSF_LOAD) && tx_en;
    assign send_go = (state == wsf_pkg::WSF_SEND) && take;
    assign sum_go = (state == wsf_pkg::WSF_CSUM) && take;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= wsf_pkg::WSF_HOLD;
        end else begin
            unique case (state)
                wsf_pkg::WSF_HOLD: begin
                    if (hold_done) begin
                        state <= wsf_pkg::WSF_LOAD;
                    end
                end
                wsf_pkg::WSF_LOAD: begin
                    if (tx_en) begin
                        state <= wsf_pkg::WSF_SEND;
                    end
                end
                wsf_pkg::WSF_SEND: begin
                    if (take && byte_left == 5'd1) begin
                        state <= wsf_pkg::WSF_CSUM;
                    end
                end
                wsf_pkg::WSF_CSUM: begin
                    if (take) begin
                        state <= wsf_pkg::WSF_LOAD;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Frame snapshot and shift
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame_sr <= 144'h0;
            byte_left <= 5'h00;
        end else if (load_go) begin
            // Snapshot the whole frame so it stays coherent
            frame_sr <= {`WSF_CH_START, flag_a, flag_b, `WSF_THIRD_FLAG,
                         w_field, t_digits, `WSF_CH_CR, `WSF_CH_LF};
            byte_left <= crlf_en ? 5'd18 : 5'd16;
        end else if (send_go) begin
            frame_sr <= {frame_sr[135:0], 8'h00};
            byte_left <= byte_left - 5'd1;
        end
    end

    // ----------------------------------------------------------------
    // Running checksum
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sum <= 8'h00;
        end else if (load_go) begin
            sum <= 8'h00;
        end else if (send_go) begin
            sum <= sum + next_byte;
        end
    end

    // ----------------------------------------------------------------
    // Byte output
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_data <= 8'h00;
            tx_valid <= 1'b0;
        end else if (send_go) begin
            tx_data <= next_byte;
            tx_valid <= 1'b1;
        end else if (sum_go) begin
            tx_data <= 8'h00 - sum;
            tx_valid <= 1'b1;
        end else if (tx_ready) begin
            tx_valid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Serial key commands
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            key_print <= 1'b0;
            key_zero <= 1'b0;
            key_tare <= 1'b0;
            key_clear <= 1'b0;
        end else begin
            key_print <= rx_valid && (rx_data == `WSF_CH_P);
            key_zero <= rx_valid && (rx_data == `WSF_CH_Z);
            key_tare <= rx_valid && (rx_data == `WSF_CH_T);
            key_clear <= rx_valid && (rx_data == `WSF_CH_C);
        end
    end

    // ----------------------------------------------------------------
    // Events and interrupt
    // ----------------------------------------------------------------
    always_comb begin
        ev_set = '0;
        ev_set[`WSF_EV_FRAME_DONE] = sum_go;
        ev_set[`WSF_EV_KEY_CMD] = rx_valid && (rx_data == `WSF_CH_P || rx_data == `WSF_CH_Z ||
                                              rx_data == `WSF_CH_T || rx_data == `WSF_CH_C);
        ev_set[`WSF_EV_BAD_CMD] = rx_valid && !ev_set[`WSF_EV_KEY_CMD];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ev_stat <= '0;
        end else if (reg_rd && reg_addr == `WSF_REG_EVENT) begin
            ev_stat <= ev_set;
        end else begin
            ev_stat <= ev_stat | ev_set;
        end
    end

    assign irq = |(ev_stat & ev_mask);

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_en <= CTRL_RESET[`WSF_CTRL_TX_EN];
            crlf_en <= CTRL_RESET[`WSF_CTRL_CRLF_EN];
            ev_mask <= `WSF_MASK_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `WSF_REG_CTRL) begin
                tx_en <= reg_wdata[`WSF_CTRL_TX_EN];
                crlf_en <= reg_wdata[`WSF_CTRL_CRLF_EN];
            end
            if (reg_addr == `WSF_REG_MASK) begin
                ev_mask <= reg_wdata[`WSF_EV_WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `WSF_REG_CTRL: reg_rdata <= {30'h0, crlf_en, tx_en};
                `WSF_REG_EVENT: reg_rdata <= {29'h0, ev_stat};
                `WSF_REG_MASK: reg_rdata <= {29'h0, ev_mask};
                `WSF_REG_STATE: reg_rdata <= {23'h0, byte_left, state};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule

//--- verif/wsf_tx_props.sv
/*
 Checker for the frame transmitter: stream hold, start byte, holdoff, keys, register port.
 Assumes it is bound to every wsf_tx instance and sees only its ports.
*/
`timescale 1ns/1ns
module wsf_tx_props #(
    parameter int unsigned HOLDOFF_CYCLES = 50
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic irq,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic key_print,
    input wire logic key_zero,
    input wire logic key_tare,
    input wire logic key_clear
);
    // ----------------------------------------------------------------
    // Edges since reset release
    // ----------------------------------------------------------------
    logic [31:0] since_rst;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            since_rst <= 32'h0;
        end else if (since_rst != 32'hFFFF_FFFF) begin
            since_rst <= since_rst + 32'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    AST_HOLDOFF: assert property (since_rst < HOLDOFF_CYCLES |-> !tx_valid)
        else $error("byte offered during holdoff");
    AST_HOLD_BYTE: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte dropped or changed while stalled");
    AST_START_BYTE: assert property ($rose(tx_valid) |-> tx_data == 8'h02)
        else $error("frame does not open with start code");
    AST_KEY_P: assert property (rx_valid && rx_data == 8'h50 |=> key_print)
        else $error("print key missing");
    AST_KEY_Z: assert property (rx_valid && rx_data == 8'h5A |=> key_zero)
        else $error("zero key missing");
    AST_KEY_T: assert property (rx_valid && rx_data == 8'h54 |=> key_tare)
        else $error("tare key missing");
    AST_KEY_C: assert property (rx_valid && rx_data == 8'h43 |=> key_clear)
        else $error("clear key missing");
    AST_KEY_NONE: assert property (!rx_valid |=> !(key_print || key_zero || key_tare || key_clear))
        else $error("key pulse without received byte");
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    AST_UNMAPPED: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    AST_MASK_OFF: assert property (reg_wr && reg_addr == 4'h8 && reg_wdata[2:0] == 3'h0 |=> !irq)
        else $error("interrupt with all events masked");
    cover property ($rose(tx_valid));
    cover property (rx_valid && rx_data == 8'h54 ##1 key_tare);
    cover property ($rose(irq));
endmodule

bind wsf_tx wsf_tx_props #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) props_u (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .key_print(key_print), .key_zero(key_zero), .key_tare(key_tare),
    .key_clear(key_clear));

//--- verif/wsf_host_link.sv
/*
 Remote display or PC taking frame bytes, promptly or with stalls.
 Assumes the byte handshake of the transmitter on clk.
*/
`timescale 1ns/1ns
module wsf_host_link (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    output logic tx_ready
);
    logic [1:0] pace;
    // Slow mode accepts one cycle in four
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pace <= 2'h0;
            tx_ready <= 1'b0;
        end else begin
            pace <= pace + 2'h1;
            tx_ready <= !slow || (pace == 2'h3);
        end
    end
endmodule

//--- verif/weigh_status_frame_tx_bench.sv
/*
 Bench for the frame transmitter: holdoff, frames, messages, keys, interrupt.
 Assumes wsf_host_link as byte sink and a 20 MHz clock.
*/
`timescale 1ns/1ns
`include "wsf_map.svh"
module weigh_status_frame_tx_bench;
    localparam int unsigned HOLD = 50;
    logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rx_valid = 0, slow = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [23:0] weight_bcd = 24'h0, tare_bcd = 24'h0;
    logic [2:0] dec_code = 3'h0, weight_cond = 3'h0;
    logic [1:0] incr_code = 2'h1;
    logic is_net = 0, is_negative = 0, is_error = 0, is_unstable = 0, power_on_zeroed = 0;
    logic [7:0] tx_data, rx_data = 8'h0;
    logic irq, tx_valid, tx_ready, key_print, key_zero, key_tare, key_clear;
    logic [7:0] exp_b [0:18];
    logic [47:0] msg [0:5];
    int error_cnt = 0, checks_done = 0, n;
    wsf_tx #(.HOLDOFF_CYCLES(HOLD)) dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .weight_bcd(weight_bcd), .tare_bcd(tare_bcd), .dec_code(dec_code), .incr_code(incr_code),
        .is_net(is_net), .is_negative(is_negative), .is_error(is_error), .is_unstable(is_unstable),
        .power_on_zeroed(power_on_zeroed), .weight_cond(weight_cond), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .key_print(key_print), .key_zero(key_zero), .key_tare(key_tare), .key_clear(key_clear));
    wsf_host_link link_u (.clk(clk), .rst_n(rst_n), .slow(slow), .tx_ready(tx_ready));
    initial begin
        forever #25 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // Access and check tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
        checks_done++;
        if (got !== want) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] want);
        @(posedge clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, want, "register");
    endtask
    task automatic key(input logic [7:0] c, input logic [3:0] want);
        @(posedge clk);
        rx_data <= c; rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
        #1 chk({28'h0, key_print, key_zero, key_tare, key_clear}, {28'h0, want}, "keys");
    endtask
    task automatic stop_tx();
        wr(`WSF_REG_CTRL, 32'h0);
        n = 0;
        for (int i = 0; i < 400 && n < 4; i++) begin
            @(negedge clk);
            n = tx_valid ? 0 : n + 1;
        end
        chk(n, 4, "stream idle");
    endtask
    // Digits right-justified, messages left-justified; checksum closes the frame
    task automatic frame(input logic [23:0] w, input logic [23:0] t, input logic [2:0] c, input bit crlf);
        logic [7:0] s, got;
        bit lead;
        int len;
        stop_tx();
        @(posedge clk);
        weight_bcd <= w; tare_bcd <= t; weight_cond <= c;
        exp_b[0] = 8'h02;
        exp_b[1] = {3'b011, incr_code, dec_code};
        exp_b[2] = {1'b0, power_on_zeroed, 2'b11, is_unstable, is_error, is_negative, is_net};
        exp_b[3] = 8'h30;
        for (int f = 0; f < 2; f++) begin
            lead = 1;
            for (int i = 5; i >= 0; i--) begin
                s = {4'h0, (f == 0 ? w[i*4+:4] : t[i*4+:4])};
                lead = lead && s == 8'h0 && i != 0;
                exp_b[4+f*6+5-i] = lead ? 8'h20 : 8'h30 + s;
                if (f == 0 && c != 3'h0 && c <= 3'h5) exp_b[9-i] = msg[c][i*8+:8];
            end
        end
        exp_b[16] = 8'h0D; exp_b[17] = 8'h0A;
        len = crlf ? 18 : 16;
        s = 8'h0;
        for (int i = 0; i < len; i++) s = s + exp_b[i];
        exp_b[len] = 8'h00 - s;
        wr(`WSF_REG_CTRL, {30'h0, crlf, 1'b1});
        n = 0;
        for (int i = 0; i < 2000 && n <= len; i++) begin
            @(negedge clk);
            if (tx_valid && tx_ready) begin
                got = tx_data;
                chk(got, exp_b[n], "frame byte");
                n++;
            end
        end
        if (n <= len) begin
            error_cnt++;
            $display("mismatch at %0t: frame timeout", $time);
            give_verdict();
        end
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        msg[0] = 48'h0; msg[1] = `WSF_MSG_UNDER; msg[2] = `WSF_MSG_OVER; msg[3] = `WSF_MSG_AOUT;
        msg[4] = `WSF_MSG_LVOLT; msg[5] = `WSF_MSG_HVOLT;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        n = 0;
        while (n < 300 && tx_valid !== 1'b1) begin
            @(negedge clk);
            n++;
        end
        chk(n >= HOLD && n <= HOLD + 4, 1, "holdoff length");
        $display("test holdoff done");
        rd_chk(`WSF_REG_CTRL, `WSF_CTRL_RESET);
        rd_chk(`WSF_REG_MASK, 32'h0);
        rd_chk(4'h2, 32'h0);
        dec_code <= 3'h5; incr_code <= 2'h3; is_net <= 1; is_unstable <= 1; power_on_zeroed <= 1;
        frame(24'h000123, 24'h000045, 3'h0, 1);
        dec_code <= 3'h2; incr_code <= 2'h2; is_net <= 0; is_negative <= 1; is_error <= 1;
        power_on_zeroed <= 0; slow <= 1;
        frame(24'h908070, 24'h000000, 3'h0, 0);
        for (int c = 1; c <= 6; c++) frame(24'h000007, 24'h123456, c[2:0], 1);
        $display("test frames done");
        stop_tx();
        rd_chk(`WSF_REG_STATE, 32'h0000_0002);
        rd_chk(`WSF_REG_EVENT, 32'h1);
        wr(`WSF_REG_MASK, 32'h0);
        key(8'h50, 4'h8);
        key(8'h5A, 4'h4);
        key(8'h54, 4'h2);
        key(8'h43, 4'h1);
        key(8'h41, 4'h0);
        chk(irq, 1'b0, "irq masked");
        wr(`WSF_REG_MASK, 32'h6);
        #1 chk(irq, 1'b1, "irq raised");
        rd_chk(`WSF_REG_EVENT, 32'h6);
        chk(irq, 1'b0, "irq cleared");
        $display("test keys done");
        give_verdict();
    end
endmodule
